/* core/gnsf_pkg.sv */
package gnsf_pkg;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_BITS = 30;
   localparam int DATA_BITS = 24;
   localparam int PAR_BITS = 6;
   localparam logic [3:0] WORD_LAST = 4'h9;
   localparam logic [4:0] BIT_LAST = 5'h1d;
   localparam logic [2:0] SF_ID_FIRST = 3'h1;
   localparam logic [2:0] SF_ID_LAST = 3'h5;
   localparam logic [7:0] PREAMBLE = 8'h8b;
   localparam logic [15:0] TELEM_RESERVED = 16'h0000;
   localparam logic [16:0] WEEK_LAST = 17'h189bf;

   // ****************************************
   // Chip reference
   // ****************************************
   localparam int CLK_HZ = 20_000_000;
   localparam logic [31:0] CHIP_RATE_DEFAULT = 32'h009c18f0;
   localparam logic [3:0] CA_DIV_LAST = 4'h9;
   localparam int CA_CHIPS_PER_BIT = 20460;
   localparam int STROBE_LATENCY = 8;

   // ****************************************
   // Parity masks, D25 in lane 5 down to D30 in lane 0
   // ****************************************
   localparam logic [5:0][23:0] PAR_MASK = {
      24'hec7cd2, 24'h763e69, 24'hbb1f34, 24'h5d8f9a, 24'haec7cd, 24'h2dea27};
   localparam logic [5:0] PAR_USE_P30 = 6'h16;

   typedef enum logic [1:0] {MODE_RAW, MODE_ENC, MODE_FRAME} gnsf_mode_t;
   typedef enum logic {ST_IDLE, ST_RUN} gnsf_st_t;

   typedef struct packed {
      logic p_en;
      logic ca_en;
   } gnsf_chip_t;

   typedef struct packed {
      logic valid;
      logic [29:0] word;
   } gnsf_uword_t;

   // Six parity bits over d1..d24 (d1 in bit 23) and the previous D29, D30
   function automatic logic [5:0] gnsf_parity(input logic [23:0] d,
                                               input logic p29,
                                               input logic p30);
      logic [5:0] p;
      p = 6'h00;
      for (int i = 0; i < PAR_BITS; i++)
      begin
         p[i] = (^(d & PAR_MASK[i])) ^ (PAR_USE_P30[i] ? p30 : p29);
      end
      return p;
   endfunction

endpackage

/* core/gnsf_chipgen.sv */
`timescale 1ns/1ps
`default_nettype none

module gnsf_chipgen #(
   parameter int CLK_HZ = gnsf_pkg::CLK_HZ,
   parameter logic [31:0] RATE_DEFAULT = gnsf_pkg::CHIP_RATE_DEFAULT
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ext_sel_i,
   input wire logic ext_clk_i,
   input wire logic [31:0] rate_i,
   input wire logic rate_load_i,
   output logic [31:0] rate_o,
   output gnsf_pkg::gnsf_chip_t chip_o
);

   localparam logic [32:0] CLK_W = 33'(CLK_HZ);

   typedef struct packed {
      logic [31:0] rate;
      logic [31:0] acc;
      logic [2:0] sync;
      logic lvl;
      logic [3:0] div;
      logic p_en;
      logic ca_en;
   } gnsf_cg_state_t;

   gnsf_cg_state_t r;
   gnsf_cg_state_t n;
   logic tick;
   logic [32:0] sum;

   // ****************************************
   // Reference select, P chip and C/A divider
   // ****************************************
   always_comb
   begin
      n = r;
      tick = 1'b0;
      sum = {1'b0, r.acc} + {1'b0, r.rate};
      n.sync = {r.sync[1:0], ext_clk_i};
      if (rate_load_i)
      begin
         n.rate = rate_i;
      end
      if (ext_sel_i)
      begin
         if ((r.sync[1] == r.sync[2]) && (r.sync[2] != r.lvl))
         begin
            n.lvl = r.sync[2];
            tick = r.sync[2];
         end
      end
      else if (sum >= CLK_W)
      begin
         n.acc = 32'(sum - CLK_W);
         tick = 1'b1;
      end
      else
      begin
         n.acc = sum[31:0];
      end
      n.p_en = tick;
      n.ca_en = 1'b0;
      if (tick)
      begin
         if (r.div == gnsf_pkg::CA_DIV_LAST)
         begin
            n.div = 4'h0;
            n.ca_en = 1'b1;
         end
         else
         begin
            n.div = r.div + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
         r.rate <= RATE_DEFAULT;
      end
      else
      begin
         r <= n;
      end
   end

   assign rate_o = r.rate;
   assign chip_o = {r.p_en, r.ca_en};

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_rate_default;
      ($past(!nrst_i) && !rate_load_i) |=> (r.rate == RATE_DEFAULT);
   endproperty
   a_rate_default: assert property (p_rate_default)
      else $error("Chip rate not at default after reset");

   property p_ext_follow;
      (ext_sel_i && r.sync[1] && r.sync[2] && !r.lvl) |=> chip_o.p_en;
   endproperty
   a_ext_follow: assert property (p_ext_follow)
      else $error("External reference edge gave no P chip");

   property p_ca_tenth;
      (chip_o.ca_en)
         |-> (chip_o.p_en && (r.div == 4'h0) && ($past(r.div) == gnsf_pkg::CA_DIV_LAST));
   endproperty
   a_ca_tenth: assert property (p_ca_tenth)
      else $error("C/A chip not every tenth P chip");

endmodule // gnsf_chipgen

`default_nettype wire

/* core/gnsf_framer.sv */
// Behaviour
// - Every word is 24 data plus 6 parity.
// - Telemetry word: preamble, bits 9-24 zero.
// - Handover word starts with 17-bit time count.
// - Handover bits 23-24 force zero trailing parity.
// - Strobe each subframe start, from second onward.
// - Strobe delayed to match output pipeline.
// - Chip reference rate settable, default 10.23 Mcps.
// - Reference from internal generator or external clock.
// - P chips run at reference rate.
// - C/A chips at reference divided by ten.
// - Provide symbol sync, bit clock, serial data.
// - Passthrough mode sends user words unchanged.
// - Parity-insert mode recomputes last six bits.
`timescale 1ns/1ps
`default_nettype none

module gnsf_framer #(
   parameter int CA_PER_BIT = gnsf_pkg::CA_CHIPS_PER_BIT,
   parameter int STROBE_DELAY = gnsf_pkg::STROBE_LATENCY,
   parameter logic [31:0] RATE_DEFAULT = gnsf_pkg::CHIP_RATE_DEFAULT
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic tx_en_i,
   input wire gnsf_pkg::gnsf_mode_t mode_i,
   input wire logic ext_ref_sel_i,
   input wire logic ext_chip_clk_i,
   input wire logic [31:0] chip_reference_rate_i,
   input wire logic rate_load_i,
   input wire gnsf_pkg::gnsf_uword_t user_i,
   output logic user_ready_o,
   output logic [31:0] chip_reference_rate_o,
   output logic p_chip_en_o,
   output logic ca_chip_en_o,
   output logic data_bit_o,
   output logic bit_clk_o,
   output logic symbol_sync_o,
   output logic subframe_strobe_o
);

   localparam int CNT_W = $clog2(CA_PER_BIT);
   localparam logic [CNT_W-1:0] CA_LAST = CNT_W'(CA_PER_BIT - 1);
   localparam logic [CNT_W-1:0] CA_HALF = CNT_W'(CA_PER_BIT / 2);

   typedef struct packed {
      gnsf_pkg::gnsf_st_t st;
      logic [CNT_W-1:0] ca_cnt;
      logic [4:0] bit_idx;
      logic [3:0] word_idx;
      logic [2:0] sf_id;
      logic first_sf;
      logic [16:0] time_of_week_count;
      logic [29:0] shreg;
      logic prev29;
      logic prev30;
      logic data_bit;
      logic bit_clk;
      logic sym_sync;
      logic [STROBE_DELAY-1:0] dly;
   } gnsf_state_t;

   gnsf_state_t r;
   gnsf_state_t n;
   gnsf_pkg::gnsf_chip_t chip;

   logic load;
   logic need_user;
   logic gen_word;
   logic solve_t;
   logic sf_start;
   logic sf_end;
   logic [29:0] src;
   logic [23:0] d;
   logic [5:0] p0;
   logic [5:0] par;
   logic [29:0] word;

   // ****************************************
   // Chip reference
   // ****************************************
   gnsf_chipgen #(
      .CLK_HZ(gnsf_pkg::CLK_HZ),
      .RATE_DEFAULT(RATE_DEFAULT)
   ) u_chipgen (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .ext_sel_i(ext_ref_sel_i),
      .ext_clk_i(ext_chip_clk_i),
      .rate_i(chip_reference_rate_i),
      .rate_load_i(rate_load_i),
      .rate_o(chip_reference_rate_o),
      .chip_o(chip)
   );

   // ****************************************
   // Word builder
   // ****************************************
   always_comb
   begin
      gen_word = (mode_i == gnsf_pkg::MODE_FRAME) && (r.word_idx < 4'h2);
      solve_t = (mode_i == gnsf_pkg::MODE_FRAME)
                && ((r.word_idx == 4'h1) || (r.word_idx == gnsf_pkg::WORD_LAST));
      need_user = !gen_word;
      src = (need_user && user_i.valid) ? user_i.word : 30'h0;
      if (!gen_word)
      begin
         d = src[29:6];
      end
      else if (r.word_idx == 4'h0)
      begin
         d = {gnsf_pkg::PREAMBLE, gnsf_pkg::TELEM_RESERVED};
      end
      else
      begin
         d = {r.time_of_week_count, 2'b00, r.sf_id, 2'b00};
      end
      p0 = gnsf_pkg::gnsf_parity({d[23:2], 2'b00}, r.prev29, r.prev30);
      if (solve_t)
      begin
         d[0] = p0[1];
         d[1] = p0[0] ^ p0[1];
      end
      par = gnsf_pkg::gnsf_parity(d, r.prev29, r.prev30);
      if (mode_i == gnsf_pkg::MODE_RAW)
      begin
         word = src;
      end
      else
      begin
         word = {d ^ {24{r.prev30}}, par};
      end
   end

   // ****************************************
   // Bit and subframe sequencer
   // ****************************************
   always_comb
   begin
      n = r;
      load = 1'b0;
      sf_start = 1'b0;
      sf_end = 1'b0;
      n.sym_sync = 1'b0;
      n.dly = r.dly << 1;
      case (r.st)
         gnsf_pkg::ST_IDLE:
         begin
            n.data_bit = 1'b0;
            n.bit_clk = 1'b0;
            if (tx_en_i)
            begin
               n.st = gnsf_pkg::ST_RUN;
               n.ca_cnt = CA_LAST;
               n.bit_idx = 5'h0;
               n.word_idx = 4'h0;
               n.sf_id = gnsf_pkg::SF_ID_FIRST;
               n.first_sf = 1'b1;
               n.prev29 = 1'b0;
               n.prev30 = 1'b0;
            end
         end
         gnsf_pkg::ST_RUN:
         begin
            if (!tx_en_i)
            begin
               n.st = gnsf_pkg::ST_IDLE;
               n.data_bit = 1'b0;
               n.bit_clk = 1'b0;
               n.dly = '0;
            end
            else if (chip.ca_en)
            begin
               if (r.ca_cnt == CA_LAST)
               begin
                  n.ca_cnt = '0;
                  n.sym_sync = 1'b1;
                  if (r.bit_idx == 5'h0)
                  begin
                     load = 1'b1;
                     n.data_bit = word[29];
                     n.shreg = {word[28:0], 1'b0};
                     n.prev29 = word[1];
                     n.prev30 = word[0];
                     sf_start = (r.word_idx == 4'h0) && !r.first_sf;
                  end
                  else
                  begin
                     n.data_bit = r.shreg[29];
                     n.shreg = {r.shreg[28:0], 1'b0};
                  end
                  if (r.bit_idx == gnsf_pkg::BIT_LAST)
                  begin
                     n.bit_idx = 5'h0;
                     if (r.word_idx == gnsf_pkg::WORD_LAST)
                     begin
                        sf_end = 1'b1;
                        n.word_idx = 4'h0;
                        n.first_sf = 1'b0;
                        n.sf_id = (r.sf_id == gnsf_pkg::SF_ID_LAST)
                                  ? gnsf_pkg::SF_ID_FIRST : r.sf_id + 3'h1;
                        n.time_of_week_count =
                           (r.time_of_week_count == gnsf_pkg::WEEK_LAST)
                           ? 17'h0 : r.time_of_week_count + 17'h1;
                     end
                     else
                     begin
                        n.word_idx = r.word_idx + 4'h1;
                     end
                  end
                  else
                  begin
                     n.bit_idx = r.bit_idx + 5'h1;
                  end
               end
               else
               begin
                  n.ca_cnt = r.ca_cnt + 1'b1;
               end
               n.bit_clk = (n.ca_cnt < CA_HALF);
            end
         end
         default:
         begin
            n.st = gnsf_pkg::ST_IDLE;
         end
      endcase
      n.dly[0] = sf_start;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign user_ready_o = load && need_user;
   assign p_chip_en_o = chip.p_en;
   assign ca_chip_en_o = chip.ca_en;
   assign data_bit_o = r.data_bit;
   assign bit_clk_o = r.bit_clk;
   assign symbol_sync_o = r.sym_sync;
   assign subframe_strobe_o = r.dly[STROBE_DELAY-1];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_word_len;
      (r.st == gnsf_pkg::ST_RUN) |-> (r.bit_idx <= gnsf_pkg::BIT_LAST);
   endproperty
   a_word_len: assert property (p_word_len)
      else $error("Bit index past 30-bit word");

   property p_telem_word;
      (load && (mode_i == gnsf_pkg::MODE_FRAME) && (r.word_idx == 4'h0))
         |-> (word[29:22] == gnsf_pkg::PREAMBLE) && (word[21:6] == 16'h0);
   endproperty
   a_telem_word: assert property (p_telem_word)
      else $error("Telemetry word preamble or reserved bits wrong");

   property p_how_time;
      (load && (mode_i == gnsf_pkg::MODE_FRAME) && (r.word_idx == 4'h1))
         |-> (word[29:13] == (r.time_of_week_count ^ {17{r.prev30}}));
   endproperty
   a_how_time: assert property (p_how_time)
      else $error("Handover word lacks time count");

   property p_how_zero;
      (load && (mode_i == gnsf_pkg::MODE_FRAME)
       && ((r.word_idx == 4'h1) || (r.word_idx == gnsf_pkg::WORD_LAST)))
         |=> (!r.prev29 && !r.prev30);
   endproperty
   a_how_zero: assert property (p_how_zero)
      else $error("Handover word trailing parity not zero");

   sequence s_sf_boundary;
      sf_start ##1 r.dly[0];
   endsequence

   property p_strobe_cause;
      subframe_strobe_o |-> $past(sf_start, STROBE_DELAY);
   endproperty
   a_strobe_cause: assert property (p_strobe_cause)
      else $error("Subframe strobe without delayed boundary");

   property p_no_first;
      (load && r.first_sf) |-> !sf_start;
   endproperty
   a_no_first: assert property (p_no_first)
      else $error("Strobe raised on first subframe");

   property p_boundary;
      (load && (r.word_idx == 4'h0) && !r.first_sf) |-> s_sf_boundary;
   endproperty
   a_boundary: assert property (p_boundary)
      else $error("Subframe start not entered in delay line");

   property p_sync_clk;
      symbol_sync_o |-> (bit_clk_o && (data_bit_o == $past(n.data_bit)));
   endproperty
   a_sync_clk: assert property (p_sync_clk)
      else $error("Symbol sync not aligned with bit clock");

   property p_raw_pass;
      (load && (mode_i == gnsf_pkg::MODE_RAW) && user_i.valid)
         |=> (r.data_bit == $past(user_i.word[29]))
             && (r.shreg[29:1] == $past(user_i.word[28:0]));
   endproperty
   a_raw_pass: assert property (p_raw_pass)
      else $error("Passthrough word altered");

   property p_enc_par;
      (load && (mode_i == gnsf_pkg::MODE_ENC))
         |=> ({r.prev29, r.prev30} == $past(par[1:0]));
   endproperty
   a_enc_par: assert property (p_enc_par)
      else $error("Inserted parity not sent");

   property p_week_step;
      sf_end |=> (r.time_of_week_count == (($past(r.time_of_week_count) == gnsf_pkg::WEEK_LAST)
                  ? 17'h0 : 17'($past(r.time_of_week_count) + 17'h1)));
   endproperty
   a_week_step: assert property (p_week_step)
      else $error("Time count did not step at subframe end");

endmodule // gnsf_framer

`default_nettype wire

/* test/gnsf_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

module gnsf_far_end #(
   parameter int HALF_NS = 500
) (
   input wire logic mclk_i,
   input wire logic run_i,
   input wire logic ext_on_i,
   input wire logic sync_i,
   input wire logic data_i,
   output logic ext_clk_o,
   output logic done_o,
   output logic [29:0] word_o
);
   logic [4:0] cnt_r;

   // ****************************************
   // Reference source, off the system clock phase
   // ****************************************
   initial ext_clk_o = 1'b0;
   always
   begin
      wait (ext_on_i);
      #(HALF_NS + 0.37) ext_clk_o = ~ext_clk_o;
   end

   // ****************************************
   // Receiver, one word per 30 symbol strobes
   // ****************************************
   always_ff @(posedge mclk_i)
   begin
      done_o <= 1'b0;
      if (!run_i)
         cnt_r <= 5'h00;
      else if (sync_i)
      begin
         word_o <= {word_o[28:0], data_i};
         cnt_r <= (cnt_r == 5'h1d) ? 5'h00 : cnt_r + 5'h01;
         done_o <= (cnt_r == 5'h1d);
      end
   end
endmodule // gnsf_far_end
`default_nettype wire

/* test/test_gnss_nav_subframe_framer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_gnss_nav_subframe_framer;
   localparam int CPB = 4;
   localparam int SDL = 3;
   localparam int BITC = CPB * 10;
   localparam int LIMIT = 90000;

   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic tx_en_i = 1'b0;
   gnsf_pkg::gnsf_mode_t mode = gnsf_pkg::MODE_RAW;
   logic ext_sel = 1'b0;
   logic ext_on = 1'b0;
   logic ext_clk;
   logic [31:0] rate = 32'h0;
   logic rate_ld = 1'b0;
   gnsf_pkg::gnsf_uword_t user = '0;
   logic ready, p_en, ca_en, dbit, bclk, sync, strobe, rx_done;
   logic [31:0] rate_o;
   logic [29:0] rx_word;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc_n = 0, p_n = 0, ca_n = 0, p_last = 0, since = 0, bit_n = 0, hi_n = 0;
   int str_n = 0, sf_cyc = 0, wd_n = 0, widx = 0, sf = 0;
   logic m29 = 1'b0;
   logic m30 = 1'b0;
   logic [29:0] uq[$];

   always #25 mclk_i = ~mclk_i;

   gnsf_framer #(.CA_PER_BIT(CPB), .STROBE_DELAY(SDL)) gnsf_framer_i (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .tx_en_i(tx_en_i),
      .mode_i(mode),
      .ext_ref_sel_i(ext_sel),
      .ext_chip_clk_i(ext_clk),
      .chip_reference_rate_i(rate),
      .rate_load_i(rate_ld),
      .user_i(user),
      .user_ready_o(ready),
      .chip_reference_rate_o(rate_o),
      .p_chip_en_o(p_en),
      .ca_chip_en_o(ca_en),
      .data_bit_o(dbit),
      .bit_clk_o(bclk),
      .symbol_sync_o(sync),
      .subframe_strobe_o(strobe)
   );

   gnsf_far_end gnsf_far_end_i (
      .mclk_i(mclk_i),
      .run_i(tx_en_i),
      .ext_on_i(ext_on),
      .sync_i(sync),
      .data_i(dbit),
      .ext_clk_o(ext_clk),
      .done_o(rx_done),
      .word_o(rx_word)
   );

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_word(input logic [29:0] got, input logic [29:0] exp);
      chk_val({2'b00, got}, {2'b00, exp}, "word");
   endtask

   task automatic chk_cnt(input int got, input int exp, input int tol, input string what);
      cmp_count++;
      if (got < exp - tol || got > exp + tol)
      begin
         num_errors++;
         $display("Error at %0t: %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   function automatic logic [5:0] par6(input logic [23:0] d, input logic q29, input logic q30);
      logic [5:0] p;
      for (int i = 0; i < 6; i++)
         p[i] = ^(d & gnsf_pkg::PAR_MASK[i]) ^ (gnsf_pkg::PAR_USE_P30[i] ? q30 : q29);
      return p;
   endfunction

   // ****************************************
   // Reference word model
   // ****************************************
   task automatic next_exp(output logic [29:0] w);
      logic [23:0] d;
      logic [5:0] p;
      w = 30'h0;
      if (mode != gnsf_pkg::MODE_FRAME || widx > 1)
      begin
         if (uq.size() > 0)
            w = uq.pop_front();
         else
            chk_cnt(0, 1, 0, "user word missing");
      end
      d = w[29:6];
      if (mode == gnsf_pkg::MODE_FRAME)
      begin
         if (widx == 0)
            d = {gnsf_pkg::PREAMBLE, gnsf_pkg::TELEM_RESERVED};
         if (widx == 1)
            d = {17'(sf), 2'b00, 3'(sf % 5 + 1), 2'b00};
         for (int t = 0; t < 4 && (widx == 1 || widx == 9); t++)
         begin
            p = par6({d[23:2], 2'(t)}, m29, m30);
            if (p[1:0] == 2'b00)
               d[1:0] = 2'(t);
         end
      end
      if (mode != gnsf_pkg::MODE_RAW)
      begin
         p = par6(d, m29, m30);
         w = {d ^ {24{m30}}, p};
      end
      m29 = w[1];
      m30 = w[0];
      widx = (widx == 9) ? 0 : widx + 1;
      if (widx == 0 && mode == gnsf_pkg::MODE_FRAME)
         sf++;
   endtask

   // ****************************************
   // Monitors and user word source
   // ****************************************
   always @(posedge mclk_i)
   begin
      logic [29:0] w;
      cyc_n++;
      if (cyc_n > LIMIT)
      begin
         num_errors++;
         print_verdict();
      end
      if (p_en === 1'b1)
         p_n++;
      if (ca_en === 1'b1)
      begin
         chk_val(32'(p_en), 32'h1, "ca without p");
         chk_cnt(p_n - p_last, 10, 0, "p per ca");
         p_last = p_n;
         ca_n++;
      end
      if (tx_en_i === 1'b1 && sync === 1'b1)
      begin
         if (bit_n > 0)
            chk_cnt(since, BITC, 0, "bit length");
         since = 0;
         bit_n++;
         if (bit_n % 300 == 1 && bit_n > 1)
            sf_cyc = cyc_n;
      end
      since++;
      if (bclk === 1'b1)
         hi_n++;
      else if (hi_n > 0)
      begin
         if (tx_en_i === 1'b1)
            chk_cnt(hi_n, BITC / 2, 0, "bit clock high");
         hi_n = 0;
      end
      if (strobe === 1'b1 && mode == gnsf_pkg::MODE_FRAME)
      begin
         str_n++;
         chk_cnt(cyc_n - sf_cyc, SDL - 1, 0, "strobe delay");
      end
      if (rx_done === 1'b1)
      begin
         next_exp(w);
         chk_word(rx_word, w);
         wd_n++;
      end
   end

   always @(posedge mclk_i)
   begin
      if (ready === 1'b1)
      begin
         uq.push_back(user.valid ? user.word : 30'h0);
         #1;
         user.valid = ($urandom % 4) != 0;
         user.word = 30'($urandom);
      end
   end

   // ****************************************
   // Test steps
   // ****************************************
   task automatic load_rate(input logic [31:0] r);
      rate = r;
      rate_ld = 1'b1;
      cyc(1);
      rate_ld = 1'b0;
      chk_val(rate_o, r, "rate readback");
   endtask

   task automatic window(input int n, input int ep, input int tol, input string what);
      int p0;
      int c0;
      p0 = p_n;
      c0 = ca_n;
      cyc(n);
      chk_cnt(p_n - p0, ep, tol, what);
      chk_cnt(ca_n - c0, ep / 10, 1, what);
      $display("test %s done, errors %0d", what, num_errors);
   endtask

   task automatic run(input gnsf_pkg::gnsf_mode_t m, input int nw, input string what);
      int k;
      mode = m;
      uq.delete();
      bit_n = 0;
      hi_n = 0;
      wd_n = 0;
      widx = 0;
      m29 = 1'b0;
      m30 = 1'b0;
      tx_en_i = 1'b1;
      k = 0;
      while (wd_n < nw && k < 30000)
      begin
         cyc(1);
         k++;
      end
      chk_cnt(wd_n, nw, 0, what);
      tx_en_i = 1'b0;
      cyc(5);
      chk_val(32'({dbit, bclk, sync}), 32'h0, "outputs after stop");
      $display("test %s done, errors %0d", what, num_errors);
   endtask

   initial
   begin
      void'($urandom(84));
      user.valid = 1'b1;
      user.word = 30'($urandom);
      cyc(10);
      chk_val(rate_o, gnsf_pkg::CHIP_RATE_DEFAULT, "default rate");
      chk_val(32'({p_en, ca_en, dbit, bclk, sync, strobe}), 32'h0, "outputs in reset");
      nrst_i = 1'b1;
      load_rate(32'h001e8480);
      window(10000, 1000, 1, "internal ref");
      load_rate(32'h000f4240);
      ext_sel = 1'b1;
      ext_on = 1'b1;
      cyc(20);
      window(10000, 500, 2, "external ref");
      ext_on = 1'b0;
      ext_sel = 1'b0;
      load_rate(32'h01312d00);
      run(gnsf_pkg::MODE_FRAME, 21, "telemetry mode");
      chk_cnt(str_n, 2, 0, "strobe count");
      run(gnsf_pkg::MODE_ENC, 8, "parity mode");
      run(gnsf_pkg::MODE_RAW, 8, "raw mode");
      print_verdict();
   end
endmodule // test_gnss_nav_subframe_framer
`default_nettype wire
